// ### bta_consts.svh
// Constants for the branch target address unit
`ifndef BTA_CONSTS_SVH
`define BTA_CONSTS_SVH
// ----------------------------------------
// Address constants
// ----------------------------------------
`define BTA_PC_W         16
`define BTA_RST_VEC_LO   16'h0000
`define BTA_RST_VEC_HI   16'h0001
`define BTA_PAGE_BASE    16'h0800
`define BTA_PAGE_MASK    16'h07ff
`define BTA_VEC_BASE     16'h0040
`define BTA_VEC_LAST     16'h007f
`endif

// ### bta_pkg.sv
// Types for the branch target address unit
package bta_pkg;
  // ----------------------------------------
  // Next-address selection
  // ----------------------------------------
  typedef enum logic [2:0] {
    BTA_SEQ   = 3'h0,  // Sequential
    BTA_REL   = 3'h1,  // Relative branch
    BTA_ABS   = 3'h3,  // Absolute branch or call
    BTA_PAGE  = 3'h2,  // Short page call
    BTA_TABLE = 3'h6,  // Table vector call
    BTA_REG   = 3'h7   // Register jump
  } bta_sel_e;

  // Unit sequencer states
  typedef enum logic [1:0] {
    BTA_ST_VLO = 2'h0,  // Reading reset vector low byte
    BTA_ST_VHI = 2'h1,  // Reading reset vector or table entry high byte
    BTA_ST_RUN = 2'h3,  // Normal operation
    BTA_ST_TLO = 2'h2   // Waiting on table entry
  } bta_state_e;
endpackage : bta_pkg

// ### bta_unit.sv
// Program counter and branch target address unit
`timescale 1ns/1ns
`default_nettype none
`include "bta_consts.svh"
module bta_unit (
  input  wire logic                   core_clk_in,       // 125 MHz core clock
  input  wire logic                   arst_n_in,         // Async reset, active low
  input  wire logic                   step_in,           // Decoder: instruction retires
  input  wire bta_pkg::bta_sel_e      sel_in,            // Decoder: address mode
  input  wire logic [2:0]             instr_len_in,      // Decoder: instruction bytes
  input  wire logic                   taken_in,          // Decoder: branch taken
  input  wire logic [7:0]             branch_displacement_in,
  input  wire logic [15:0]            absolute_target_in,
  input  wire logic [10:0]            page_target_in,
  input  wire logic [7:0]             opcode_imm_in,     // Immediate field holding vector index
  input  wire logic [15:0]            accumulator_pair_in,
  input  wire logic [7:0]             mem_data_in,       // Program memory read data
  output logic [15:0]                 mem_addr_out,      // Program memory read address
  output logic                        mem_rd_out,        // Program memory read strobe
  output logic [15:0]                 pc_out,            // Program counter
  output logic                        ready_out          // Unit accepts steps
);
  import bta_pkg::*;

  // Steps are honoured only in the run state; the decoder watches ready_out
  // A table call stalls the core for three extra cycles while the entry is read
  // Limitation: program memory must answer one cycle after the address
  // Trade-off: one adder chain serves both sequential and relative targets

  bta_state_e  state_r;         // Sequencer state
  logic [15:0] pc_r;            // Program counter
  logic [7:0]  lo_r;            // Low byte of a fetched vector
  logic [15:0] seq_addr;        // Start of following instruction
  logic [15:0] rel_addr;        // Relative target
  logic [15:0] disp_ext;        // Sign-extended displacement
  logic [15:0] vec_addr;        // Vector entry address
  logic [4:0]  vector_index;    // Table index

  // ----------------------------------------
  // Target arithmetic
  // ----------------------------------------
  // Combinational targets; all adds are 16 bits so carry drops
  always_comb begin
    seq_addr     = pc_r + {13'h0000, instr_len_in};
    disp_ext     = {{8{branch_displacement_in[7]}}, branch_displacement_in};
    rel_addr     = seq_addr + disp_ext;
    vector_index = opcode_imm_in[5:1];
    vec_addr     = `BTA_VEC_BASE | {10'h000, vector_index, 1'b0};
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Reset fetches the vector; table calls take two reads
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= BTA_ST_VLO;
      pc_r    <= 16'h0000;
      lo_r    <= 8'h00;
    end else begin
      unique case (state_r)
        // First cycle after reset: capture the vector low byte
        BTA_ST_VLO: begin
          lo_r    <= mem_data_in;      // Low byte at reset vector
          state_r <= BTA_ST_VHI;
        end
        // High byte arrives: reset vector or table entry completes the PC
        BTA_ST_VHI: begin
          pc_r    <= {mem_data_in, lo_r};
          state_r <= BTA_ST_RUN;
        end
        // Table entry low byte is on the bus this cycle
        BTA_ST_TLO: begin
          lo_r    <= mem_data_in;      // Low byte of entry
          state_r <= BTA_ST_VHI;       // High byte then loads PC
        end
        // Normal running: one retiring instruction per step
        BTA_ST_RUN: begin
          if (step_in) begin
            if (!taken_in) begin
              pc_r <= seq_addr;
            end else begin
              unique case (sel_in)
                BTA_REL:   pc_r <= rel_addr;
                BTA_ABS:   pc_r <= absolute_target_in;
                BTA_PAGE:  pc_r <= `BTA_PAGE_BASE | {5'h00, page_target_in};
                BTA_TABLE: state_r <= BTA_ST_TLO;
                BTA_REG:   pc_r <= accumulator_pair_in;
                default:   pc_r <= seq_addr;  // Sequential code taken flag
              endcase
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Memory port
  // ----------------------------------------
  // Registered address so output comes from a flop; one-cycle read latency assumed
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mem_addr_out <= `BTA_RST_VEC_LO;
      mem_rd_out   <= 1'b1;
    end else begin
      unique case (state_r)
        // Vector fetch after reset: move on to the high byte
        BTA_ST_VLO: begin
          mem_addr_out <= (mem_addr_out == `BTA_RST_VEC_LO) ? `BTA_RST_VEC_HI : vec_addr + 16'h0001;
          mem_rd_out   <= 1'b1;
        end
        // Run, high byte or table entry: follow or start a read
        default: begin
          mem_addr_out <= (step_in && taken_in && sel_in == BTA_TABLE && state_r == BTA_ST_RUN)
                          ? vec_addr : mem_addr_out + 16'h0001;
          mem_rd_out   <= (state_r == BTA_ST_RUN && step_in && taken_in && sel_in == BTA_TABLE)
                          || state_r == BTA_ST_TLO;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // pc_out trails pc_r by one cycle; ready_out drops on the table-call edge
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pc_out    <= 16'h0000;
      ready_out <= 1'b0;
    end else begin
      pc_out    <= pc_r;
      ready_out <= (state_r == BTA_ST_RUN) && !(step_in && taken_in && sel_in == BTA_TABLE);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Concurrent checks, all held off while reset is low
  // They watch the registered PC and the memory port against the decoder inputs

  // ----------------------------------------
  // Reset vector fetch
  // ----------------------------------------
  // The two vector bytes come from fixed addresses, low byte first
  reset_vec_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_r == BTA_ST_VLO) |-> (mem_addr_out == `BTA_RST_VEC_LO && mem_rd_out)
      ##1 (mem_addr_out == `BTA_RST_VEC_HI && mem_rd_out) ##1 (pc_r == {$past(mem_data_in), $past(lo_r)}))
    else $error("reset vector fetch wrong");

  // A step offered while a vector is read must leave the PC alone
  step_refused_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_r == BTA_ST_VLO || state_r == BTA_ST_TLO) |=> pc_r == $past(pc_r))
    else $error("step taken during fetch");

  // ----------------------------------------
  // Sequential and relative targets
  // ----------------------------------------
  // Not taken advances by the instruction length
  seq_step_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_r == BTA_ST_RUN && step_in && !taken_in) |=> pc_r == $past(pc_r) + 16'($past(instr_len_in)))
    else $error("sequential step wrong");

  // Taken with the sequential code also just advances
  taken_seq_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_r == BTA_ST_RUN && step_in && taken_in && sel_in == BTA_SEQ)
      |=> pc_r == $past(pc_r) + 16'($past(instr_len_in)))
    else $error("sequential code not advanced");

  // Relative target is the following instruction plus displacement
  rel_target_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_r == BTA_ST_RUN && step_in && taken_in && sel_in == BTA_REL) |=> pc_r == $past(rel_addr))
    else $error("relative target wrong");

  // Checked on the loaded PC so a wrong sign fill cannot hide
  sign_ext_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_r == BTA_ST_RUN && step_in && taken_in && sel_in == BTA_REL)
      |=> 16'(pc_r - $past(seq_addr)) == {{8{$past(branch_displacement_in[7])}}, $past(branch_displacement_in)})
    else $error("sign extension wrong");

  // ----------------------------------------
  // Absolute, page and register targets
  // ----------------------------------------
  // Absolute immediate lands unchanged
  abs_load_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_r == BTA_ST_RUN && step_in && taken_in && sel_in == BTA_ABS) |=> pc_r == $past(absolute_target_in))
    else $error("absolute target wrong");

  // Page call can never leave the fixed page
  page_range_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_r == BTA_ST_RUN && step_in && taken_in && sel_in == BTA_PAGE) |=> pc_r[15:11] == 5'h01)
    else $error("page call out of page");

  // Register jump copies the pair as it stood at the step
  reg_jump_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_r == BTA_ST_RUN && step_in && taken_in && sel_in == BTA_REG) |=> pc_r == $past(accumulator_pair_in))
    else $error("register jump wrong");

  // ----------------------------------------
  // Table vector call
  // ----------------------------------------
  // Entry address follows the index field, two bytes per entry
  vec_index_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_r == BTA_ST_RUN && step_in && taken_in && sel_in == BTA_TABLE)
      |=> mem_addr_out == `BTA_VEC_BASE + {10'h000, $past(opcode_imm_in[5:1]), 1'b0})
    else $error("vector index wrong");

  // Both entry reads stay inside the vector table, low byte even
  vec_range_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_r == BTA_ST_RUN && step_in && taken_in && sel_in == BTA_TABLE)
      |=> (mem_rd_out && !mem_addr_out[0] && mem_addr_out >= `BTA_VEC_BASE && mem_addr_out < `BTA_VEC_LAST)
      ##1 (mem_rd_out && mem_addr_out <= `BTA_VEC_LAST))
    else $error("vector entry out of table");

  // Entry bytes land in the PC once the high byte is read
  table_load_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_r == BTA_ST_RUN && step_in && taken_in && sel_in == BTA_TABLE)
      |=> ##2 pc_r == {$past(mem_data_in), $past(lo_r)})
    else $error("table call load wrong");

  // ----------------------------------------
  // Handshake
  // ----------------------------------------
  // Ready stays low while any fetch is under way
  ready_drop_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_r != BTA_ST_RUN || (step_in && taken_in && sel_in == BTA_TABLE)) |=> !ready_out)
    else $error("ready high during fetch");

  // Memory is only read while a vector or entry is fetched
  rd_quiet_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    mem_rd_out |-> state_r != BTA_ST_RUN)
    else $error("memory read outside fetch");
endmodule : bta_unit
`default_nettype wire

// ### bta_prog_mem.sv
// Program memory model facing the unit
`timescale 1ns/1ns
`default_nettype none
module bta_prog_mem (
  input  wire logic [15:0] addr_in,  // Read address
  input  wire logic        rd_in,    // Read strobe
  output logic [7:0]       data_out  // Read data
);
  // Byte pattern, reset vector bytes at 0000H and 0001H included
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    return (a[7:0] * 8'h07) + 8'h03;
  endfunction : byte_at
  // Without a strobe the bus shows inverted data, never a stale byte
  assign data_out = rd_in ? byte_at(addr_in) : ~byte_at(addr_in);
endmodule : bta_prog_mem
`default_nettype wire

// ### tb.sv
// Self-checking bench for the branch target address unit
`timescale 1ns/1ns
`default_nettype none
module tb;
  import bta_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic       core_clk, arst_n, step, taken, mrd, rdy;
  bta_sel_e   sel;
  logic [2:0] len;
  logic [7:0] disp, imm, mdata;
  logic [10:0] page;
  logic [15:0] abs_t, acc, maddr, pc, cur;  // cur is the expected PC
  int         fail_count, total_checks, cyc;
  bta_unit uut (.core_clk_in(core_clk), .arst_n_in(arst_n), .step_in(step), .sel_in(sel),
    .instr_len_in(len), .taken_in(taken), .branch_displacement_in(disp), .absolute_target_in(abs_t),
    .page_target_in(page), .opcode_imm_in(imm), .accumulator_pair_in(acc), .mem_data_in(mdata),
    .mem_addr_out(maddr), .mem_rd_out(mrd), .pc_out(pc), .ready_out(rdy));
  bta_prog_mem mem (.addr_in(maddr), .rd_in(mrd), .data_out(mdata));
  // Same byte pattern as the memory model, kept apart on purpose
  function automatic logic [7:0] mb(input logic [15:0] a);
    return (a[7:0] * 8'h07) + 8'h03;
  endfunction : mb
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Hang guard: the whole run needs well under 200 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 500) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // One retiring instruction, then wait for the unit to settle
  task automatic go(input bta_sel_e s, input logic t, input logic [2:0] l, input string nm);
    int n;
    sel = s;
    taken = t;
    len = l;
    step = 1'b1;
    @(negedge core_clk);
    step = 1'b0;
    check({15'h0000, rdy}, (s == BTA_TABLE && t) ? 16'h0000 : 16'h0001);
    @(negedge core_clk);
    for (n = 0; n < 8 && rdy !== 1'b1; n++) @(negedge core_clk);
    check(pc, cur);
    check({15'h0000, rdy}, 16'h0001);
    $display("test %s done", nm);
  endtask : go
  // Reset in mid-run; a step offered during the vector fetch must be ignored
  task automatic mid_reset(input string nm);
    arst_n = 1'b0;
    @(negedge core_clk);
    check(pc, 16'h0000);
    check({15'h0000, rdy}, 16'h0000);
    arst_n = 1'b1;
    sel = BTA_ABS;
    taken = 1'b1;
    abs_t = 16'h1234;
    step = 1'b1;
    repeat (2) @(negedge core_clk);
    step = 1'b0;
    @(negedge core_clk);
    check(pc, {mb(16'h0001), mb(16'h0000)});
    check({15'h0000, rdy}, 16'h0001);
    $display("test %s done", nm);
  endtask : mid_reset
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  initial begin
    {arst_n, step, taken, len, disp, imm, page, abs_t, acc} = '0;
    sel = BTA_SEQ;
    repeat (6) @(negedge core_clk);
    arst_n = 1'b1;
    for (int n = 0; n < 10 && rdy !== 1'b1; n++) @(negedge core_clk);
    cur = {mb(16'h0001), mb(16'h0000)};
    check(pc, cur);
    cur = cur + 16'h0003;
    go(BTA_REL, 1'b0, 3'h3, "seq");
    disp = 8'h80;
    cur = cur + 16'h0002 + 16'hff80;
    go(BTA_REL, 1'b1, 3'h2, "rel_neg");
    disp = 8'h7f;
    cur = cur + 16'h0002 + 16'h007f;
    go(BTA_REL, 1'b1, 3'h2, "rel_pos");
    abs_t = 16'hfffe;
    cur = 16'hfffe;
    go(BTA_ABS, 1'b1, 3'h3, "abs");
    disp = 8'h05;
    cur = 16'h0005;
    go(BTA_REL, 1'b1, 3'h2, "wrap");
    page = 11'h7ff;
    cur = 16'h0fff;
    go(BTA_PAGE, 1'b1, 3'h2, "page");
    imm = 8'hff;
    cur = {mb(16'h007f), mb(16'h007e)};
    go(BTA_TABLE, 1'b1, 3'h1, "table_top");
    imm = 8'h01;
    cur = {mb(16'h0041), mb(16'h0040)};
    go(BTA_TABLE, 1'b1, 3'h1, "table_base");
    acc = 16'h5aa5;
    cur = 16'h5aa5;
    go(BTA_REG, 1'b1, 3'h2, "reg");
    mid_reset("mid_reset");
    cur = {mb(16'h0001), mb(16'h0000)} + 16'h0001;
    go(BTA_SEQ, 1'b1, 3'h1, "taken_seq");
    end_sim();
  end
endmodule : tb
`default_nettype wire
